// file: src/cat_pkg.sv
// Constants, field layouts and types shared by the automatic transmit trigger block.
// Assumes the block clock is the device oscillator, so one Tosc equals one clk cycle.
package cat_pkg;
    localparam int NUM_CH = 4;
    localparam int ERR_EVENTS = 5;

    // Register addresses on the register write and read port.
    localparam logic [7:0] ADDR_THR_EN = 8'h04;
    localparam logic [7:0] ADDR_POLARITY = 8'h05;
    localparam logic [7:0] ADDR_CMP_BASE = 8'h06;
    localparam logic [7:0] ADDR_STATUS = 8'h0a;
    localparam logic [7:0] ADDR_SCHED = 8'h10;
    localparam logic [7:0] ADDR_OPT2 = 8'h11;

    // Reset values.
    localparam logic [7:0] RST_SCHED = 8'h3f;
    localparam logic [7:0] RST_OPT2 = 8'h00;
    localparam logic [3:0] RST_THR_EN = 4'h0;
    localparam logic [3:0] RST_POLARITY = 4'h0;
    localparam logic [7:0] RST_CMP = 8'h00;

    // Field positions in scheduled_tx_control and option_ctrl_two.
    localparam int SCHED_EN_BIT = 7;
    localparam int SCHED_SEL_BIT = 6;
    localparam int SCHED_BASE_LSB = 4;
    localparam int SCHED_MULT_LSB = 0;
    localparam int OPT2_ERR_MSG_BIT = 5;

    // Forced low compare bits for each polarity.
    localparam logic [1:0] CMP_LOW_ABOVE = 2'h3;
    localparam logic [1:0] CMP_LOW_BELOW = 2'h0;

    // Transmit identifier slots and data length codes.
    localparam logic [1:0] SLOT_PERIODIC = 2'h0;
    localparam logic [1:0] SLOT_ERROR = 2'h1;
    localparam logic [1:0] SLOT_EVENT = 2'h2;
    localparam logic [3:0] DLC_ANALOG = 4'h8;
    localparam logic [3:0] DLC_ERROR = 4'h3;
    localparam logic [3:0] DLC_EMPTY = 4'h0;

    // Base period is 4096 oscillator periods; the block clock is the oscillator.
    localparam int OSC_PERIODS_PER_BASE = 4096;
    localparam int CLK_PER_OSC = 1;
    localparam int BASE_CYCLES = OSC_PERIODS_PER_BASE * CLK_PER_OSC;
    localparam logic [11:0] BASE_STEP_1 = 12'h000;
    localparam logic [11:0] BASE_STEP_16 = 12'h00f;
    localparam logic [11:0] BASE_STEP_256 = 12'h0ff;
    localparam logic [11:0] BASE_STEP_4096 = 12'hfff;

    typedef enum logic [1:0] {
        CAT_SRC_NONE = 2'b00,
        CAT_SRC_ANALOG = 2'b01,
        CAT_SRC_ERROR = 2'b10
    } cat_src_e;
endpackage

// file: src/cat_thresh_chan.sv
// One analog channel's threshold detector with forced two-bit hysteresis.
// Assumes one conversion result arrives per sample_valid pulse for this channel.
`timescale 1ns/1ns
module cat_thresh_chan (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic trig_above,
    input wire logic [7:0] cmp_high,
    input wire logic sample_valid,
    input wire logic [9:0] sample,
    output logic fire,
    output logic armed
);
    typedef struct packed {
        logic armed;
        logic fire;
    } cat_chan_s;

    cat_chan_s s_q, s_d;
    logic [9:0] upper_bound;
    logic [9:0] lower_bound;

    // The low bits are never stored, so software cannot set them.
    assign upper_bound = {cmp_high, cat_pkg::CMP_LOW_ABOVE};
    assign lower_bound = {cmp_high, cat_pkg::CMP_LOW_BELOW};

    always_comb begin
        s_d = s_q;
        s_d.fire = 1'b0;
        if (!enable) begin
            s_d.armed = 1'b1;
        end else if (sample_valid) begin
            if (trig_above) begin
                if (s_q.armed && sample >= upper_bound) begin
                    s_d.fire = 1'b1;
                    s_d.armed = 1'b0;
                end else if (sample <= lower_bound) begin
                    s_d.armed = 1'b1;
                end
            end else begin
                if (s_q.armed && sample <= lower_bound) begin
                    s_d.fire = 1'b1;
                    s_d.armed = 1'b0;
                end else if (sample >= upper_bound) begin
                    s_d.armed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{armed: 1'b1, fire: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign fire = s_q.fire;
    assign armed = s_q.armed;
endmodule

// file: src/cat_sched_timer.sv
// Periodic tick generator: prescaler, base period selector and multiplier.
// Assumes the configuration may change at any time; counters past a new limit wrap.
`timescale 1ns/1ns
module cat_sched_timer #(
    parameter int PRESCALE = cat_pkg::BASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [1:0] base_sel,
    input wire logic [3:0] mult,
    output logic tick
);
    typedef struct packed {
        logic [11:0] pre;
        logic [11:0] base;
        logic [3:0] mult;
        logic tick;
    } cat_timer_s;

    cat_timer_s s_q, s_d;
    logic [11:0] base_limit;
    logic [11:0] pre_limit;

    assign pre_limit = 12'(PRESCALE - 1);

    always_comb begin
        unique case (base_sel)
            2'b00: base_limit = cat_pkg::BASE_STEP_1;
            2'b01: base_limit = cat_pkg::BASE_STEP_16;
            2'b10: base_limit = cat_pkg::BASE_STEP_256;
            2'b11: base_limit = cat_pkg::BASE_STEP_4096;
        endcase
    end

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!enable) begin
            s_d = '0;
        end else if (s_q.pre < pre_limit) begin
            s_d.pre = s_q.pre + 12'h001;
        end else begin
            s_d.pre = '0;
            if (s_q.base < base_limit) begin
                s_d.base = s_q.base + 12'h001;
            end else begin
                s_d.base = '0;
                // Interval is base period times (mult + 1).
                if (s_q.mult < mult) begin
                    s_d.mult = s_q.mult + 4'h1;
                end else begin
                    s_d.mult = '0;
                    s_d.tick = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;
endmodule

// file: src/cat_auto_tx.sv
// Automatic transmit request generator: threshold, error and scheduled sources.
// Assumes the CAN engine takes a request with a one-cycle tx_ack and fetches the payload itself.
`timescale 1ns/1ns
module cat_auto_tx #(
    parameter int PRESCALE = cat_pkg::BASE_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_mask,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_addr,
    output logic [7:0] reg_rd_data,
    input wire logic [3:0] analog_input_cfg,
    input wire logic adc_valid,
    input wire logic [1:0] adc_channel,
    input wire logic [9:0] adc_result,
    input wire logic rx_warn,
    input wire logic rx_passive,
    input wire logic tx_warn,
    input wire logic tx_passive,
    input wire logic rx_overflow,
    input wire logic tx_ack,
    output logic tx_req,
    output logic [1:0] tx_slot,
    output logic [3:0] tx_dlc,
    output logic [1:0] tx_src,
    output logic [2:0] tx_pending
);
    typedef struct packed {
        logic [3:0] thr_en;
        logic [3:0] polarity;
        logic [3:0][7:0] cmp_high;
        logic [7:0] sched;
        logic [7:0] opt2;
        logic [4:0] err_prev;
        logic [2:0] pend;
        logic req;
        logic [1:0] slot;
        logic [3:0] data_length_code;
        cat_pkg::cat_src_e src;
        logic [7:0] rd_data;
    } cat_top_s;

    cat_top_s s_q, s_d;
    logic [3:0] chan_fire;
    logic [3:0] chan_armed;
    logic sched_tick;
    logic [4:0] err_now;
    logic [4:0] err_entry;
    logic thr_event;
    logic err_event;
    logic [2:0] pend_set;

    // Masked write keeps the bits whose mask bit is clear.
    function automatic logic [7:0] masked_write(
        input logic [7:0] old_value,
        input logic [7:0] mask,
        input logic [7:0] value
    );
        masked_write = (old_value & ~mask) | (value & mask);
    endfunction

    // Index of a compare register, valid only when is_cmp_addr is true.
    function automatic logic [1:0] cmp_index(input logic [7:0] addr);
        logic [7:0] delta;
        delta = addr - cat_pkg::ADDR_CMP_BASE;
        cmp_index = delta[1:0];
    endfunction

    function automatic logic is_cmp_addr(input logic [7:0] addr);
        is_cmp_addr = (addr >= cat_pkg::ADDR_CMP_BASE) &&
            (addr < cat_pkg::ADDR_CMP_BASE + 8'(cat_pkg::NUM_CH));
    endfunction

    genvar ch;
    generate
        for (ch = 0; ch < cat_pkg::NUM_CH; ch++) begin : g_chan
            cat_thresh_chan u_chan (
                .clk(clk),
                .rst_b(rst_b),
                .enable(s_q.thr_en[ch] & analog_input_cfg[ch]),
                .trig_above(s_q.polarity[ch]),
                .cmp_high(s_q.cmp_high[ch]),
                .sample_valid(adc_valid && (adc_channel == 2'(ch))),
                .sample(adc_result),
                .fire(chan_fire[ch]),
                .armed(chan_armed[ch])
            );
        end
    endgenerate

    cat_sched_timer #(
        .PRESCALE(PRESCALE)
    ) u_sched (
        .clk(clk),
        .rst_b(rst_b),
        .enable(s_q.sched[cat_pkg::SCHED_EN_BIT]),
        .base_sel(s_q.sched[cat_pkg::SCHED_BASE_LSB +: 2]),
        .mult(s_q.sched[cat_pkg::SCHED_MULT_LSB +: 4]),
        .tick(sched_tick)
    );

    assign err_now = {rx_overflow, tx_passive, tx_warn, rx_passive, rx_warn};
    // A state that persists is seen once, at its rising edge.
    assign err_entry = err_now & ~s_q.err_prev;
    assign thr_event = |chan_fire;
    assign err_event = (|err_entry) & s_q.opt2[cat_pkg::OPT2_ERR_MSG_BIT];
    assign pend_set = {thr_event, err_event, sched_tick};

    always_comb begin
        s_d = s_q;
        s_d.err_prev = err_now;

        // Register writes through the masked write port.
        if (reg_wr_en) begin
            unique case (reg_wr_addr)
                cat_pkg::ADDR_THR_EN: begin
                    s_d.thr_en = 4'(masked_write({4'h0, s_q.thr_en}, reg_wr_mask, reg_wr_data));
                end
                cat_pkg::ADDR_POLARITY: begin
                    s_d.polarity = 4'(masked_write({4'h0, s_q.polarity}, reg_wr_mask, reg_wr_data));
                end
                cat_pkg::ADDR_SCHED: begin
                    s_d.sched = masked_write(s_q.sched, reg_wr_mask, reg_wr_data);
                end
                cat_pkg::ADDR_OPT2: begin
                    s_d.opt2 = masked_write(s_q.opt2, reg_wr_mask, reg_wr_data);
                end
                default: begin
                    if (is_cmp_addr(reg_wr_addr)) begin
                        s_d.cmp_high[cmp_index(reg_wr_addr)] =
                            masked_write(s_q.cmp_high[cmp_index(reg_wr_addr)], reg_wr_mask, reg_wr_data);
                    end
                end
            endcase
        end

        // Register reads are answered one cycle later; unmapped reads return zero.
        unique case (reg_rd_addr)
            cat_pkg::ADDR_THR_EN: begin
                s_d.rd_data = {4'h0, s_q.thr_en};
            end
            cat_pkg::ADDR_POLARITY: begin
                s_d.rd_data = {4'h0, s_q.polarity};
            end
            cat_pkg::ADDR_STATUS: begin
                s_d.rd_data = {s_q.req, chan_armed, s_q.pend};
            end
            cat_pkg::ADDR_SCHED: begin
                s_d.rd_data = s_q.sched;
            end
            cat_pkg::ADDR_OPT2: begin
                s_d.rd_data = s_q.opt2;
            end
            default: begin
                if (is_cmp_addr(reg_rd_addr)) begin
                    s_d.rd_data = s_q.cmp_high[cmp_index(reg_rd_addr)];
                end else begin
                    s_d.rd_data = 8'h00;
                end
            end
        endcase

        // The offered slot is cleared on acknowledge; a new event in that cycle wins.
        if (s_q.req && tx_ack) begin
            s_d.req = 1'b0;
            s_d.pend[s_q.slot] = 1'b0;
        end
        s_d.pend = s_d.pend | pend_set;

        // A request, once offered, stands until taken, so a scheduled one may be delayed.
        if (!s_q.req) begin
            if (s_q.pend[2]) begin
                s_d.req = 1'b1;
                s_d.slot = cat_pkg::SLOT_EVENT;
                s_d.data_length_code = cat_pkg::DLC_ANALOG;
                s_d.src = cat_pkg::CAT_SRC_ANALOG;
            end else if (s_q.pend[1]) begin
                s_d.req = 1'b1;
                s_d.slot = cat_pkg::SLOT_ERROR;
                s_d.data_length_code = cat_pkg::DLC_ERROR;
                s_d.src = cat_pkg::CAT_SRC_ERROR;
            end else if (s_q.pend[0]) begin
                s_d.req = 1'b1;
                s_d.slot = cat_pkg::SLOT_PERIODIC;
                if (s_q.sched[cat_pkg::SCHED_SEL_BIT]) begin
                    s_d.data_length_code = cat_pkg::DLC_ANALOG;
                    s_d.src = cat_pkg::CAT_SRC_ANALOG;
                end else begin
                    s_d.data_length_code = cat_pkg::DLC_EMPTY;
                    s_d.src = cat_pkg::CAT_SRC_NONE;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q.thr_en <= cat_pkg::RST_THR_EN;
            s_q.polarity <= cat_pkg::RST_POLARITY;
            s_q.cmp_high <= {cat_pkg::NUM_CH{cat_pkg::RST_CMP}};
            s_q.sched <= cat_pkg::RST_SCHED;
            s_q.opt2 <= cat_pkg::RST_OPT2;
            s_q.err_prev <= 5'h00;
            s_q.pend <= 3'h0;
            s_q.req <= 1'b0;
            s_q.slot <= cat_pkg::SLOT_PERIODIC;
            s_q.data_length_code <= cat_pkg::DLC_EMPTY;
            s_q.src <= cat_pkg::CAT_SRC_NONE;
            s_q.rd_data <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rd_data = s_q.rd_data;
    assign tx_req = s_q.req;
    assign tx_slot = s_q.slot;
    assign tx_dlc = s_q.data_length_code;
    assign tx_src = s_q.src;
    assign tx_pending = s_q.pend;
endmodule

// file: testbench/cat_can_engine.sv
// Behavioural CAN engine that takes transmit requests from the block.
// Assumes tx_req stays up until acknowledged; ack_delay sets the stall.
`timescale 1ns/1ns
module cat_can_engine (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic tx_req,
    input wire logic [4:0] ack_delay,
    output logic tx_ack
);
    logic [4:0] wait_q;
    // A frame on the wire takes time, so the engine may leave a request waiting.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 5'h00;
            tx_ack <= 1'b0;
        end else if (tx_req && !tx_ack && wait_q >= ack_delay) begin
            wait_q <= 5'h00;
            tx_ack <= 1'b1;
        end else begin
            wait_q <= (tx_req && !tx_ack) ? wait_q + 5'h01 : 5'h00;
            tx_ack <= 1'b0;
        end
    end
endmodule

// file: testbench/cat_auto_tx_assertions.sv
// Concurrent checks on the transmit request side of the block.
// Assumes it is bound to cat_auto_tx and sees only its ports.
`timescale 1ns/1ns
module cat_auto_tx_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_addr,
    input wire logic [7:0] reg_wr_mask,
    input wire logic [7:0] reg_wr_data,
    input wire logic rx_warn,
    input wire logic rx_passive,
    input wire logic tx_warn,
    input wire logic tx_passive,
    input wire logic rx_overflow,
    input wire logic tx_ack,
    input wire logic tx_req,
    input wire logic [1:0] tx_slot,
    input wire logic [3:0] tx_dlc,
    input wire logic [1:0] tx_src,
    input wire logic [2:0] tx_pending
);
    logic err_en_q;
    logic err_en_d;
    // Shadow of the error message enable, so entries can be tied to it.
    always_comb begin
        err_en_d = err_en_q;
        if (reg_wr_en && reg_wr_addr == cat_pkg::ADDR_OPT2 && reg_wr_mask[cat_pkg::OPT2_ERR_MSG_BIT]) begin
            err_en_d = reg_wr_data[cat_pkg::OPT2_ERR_MSG_BIT];
        end
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            err_en_q <= 1'b0;
        end else begin
            err_en_q <= err_en_d;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    property p_hold;
        tx_req && !tx_ack |=> tx_req && $stable({tx_slot, tx_dlc, tx_src});
    endproperty
    a_hold: assert property (p_hold) else $error("request changed before ack");
    property p_drop;
        tx_req && tx_ack |=> !tx_req;
    endproperty
    a_drop: assert property (p_drop) else $error("request not dropped after ack");
    property p_evt;
        tx_req && tx_slot == 2'h2 |-> tx_dlc == 4'h8 && tx_src == 2'h1;
    endproperty
    a_evt: assert property (p_evt) else $error("event frame format wrong");
    property p_err;
        tx_req && tx_slot == 2'h1 |-> tx_dlc == 4'h3 && tx_src == 2'h2;
    endproperty
    a_err: assert property (p_err) else $error("error frame format wrong");
    property p_per;
        tx_req && tx_slot == 2'h0 |-> (tx_dlc == 4'h8 && tx_src == 2'h1) || (tx_dlc == 4'h0 && tx_src == 2'h0);
    endproperty
    a_per: assert property (p_per) else $error("periodic frame format wrong");
    property p_prio;
        $rose(tx_req) |-> $past(tx_pending) != 3'h0
            && tx_slot == ($past(tx_pending[2]) ? 2'h2 : $past(tx_pending[1]) ? 2'h1 : 2'h0);
    endproperty
    a_prio: assert property (p_prio) else $error("slot priority wrong");
    property p_pend;
        tx_req && !tx_ack |=> tx_pending[tx_slot];
    endproperty
    a_pend: assert property (p_pend) else $error("offered slot lost its pending bit");
    property p_entry;
        ($rose(rx_warn) || $rose(rx_passive) || $rose(tx_warn) || $rose(tx_passive) || $rose(rx_overflow))
            && err_en_q |=> tx_pending[1];
    endproperty
    a_entry: assert property (p_entry) else $error("error entry not made pending");
endmodule
bind cat_auto_tx cat_auto_tx_assertions u_cat_auto_tx_assertions (.clk(clk), .rst_b(rst_b),
    .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .reg_wr_mask(reg_wr_mask), .reg_wr_data(reg_wr_data),
    .rx_warn(rx_warn), .rx_passive(rx_passive), .tx_warn(tx_warn), .tx_passive(tx_passive),
    .rx_overflow(rx_overflow), .tx_ack(tx_ack), .tx_req(tx_req), .tx_slot(tx_slot), .tx_dlc(tx_dlc),
    .tx_src(tx_src), .tx_pending(tx_pending));

// file: testbench/tb_cat_auto_tx.sv
// Self-checking bench for the automatic transmit block and a CAN engine model.
// Assumes PRESCALE shortened to 4 so scheduled intervals stay brief.
`timescale 1ns/1ns
module tb_cat_auto_tx;
    localparam int PRESCALE = 4;
    localparam logic [7:0] F_EVT = {cat_pkg::SLOT_EVENT, cat_pkg::DLC_ANALOG, 2'h1};
    localparam logic [7:0] F_ERR = {cat_pkg::SLOT_ERROR, cat_pkg::DLC_ERROR, 2'h2};
    localparam logic [7:0] F_P8 = {cat_pkg::SLOT_PERIODIC, cat_pkg::DLC_ANALOG, 2'h1};
    localparam logic [7:0] F_P0 = {cat_pkg::SLOT_PERIODIC, cat_pkg::DLC_EMPTY, 2'h0};
    localparam logic [9:0] HI = {8'h40, cat_pkg::CMP_LOW_ABOVE};
    localparam logic [9:0] LO = {8'h40, cat_pkg::CMP_LOW_BELOW};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wr_addr = 8'h00;
    logic [7:0] reg_wr_mask = 8'h00;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] reg_rd_addr = 8'h00;
    logic [7:0] reg_rd_data;
    logic [3:0] analog_input_cfg = 4'h0;
    logic adc_valid = 1'b0;
    logic [1:0] adc_channel = 2'h0;
    logic [9:0] adc_result = 10'h000;
    logic [4:0] err_in = 5'h00;
    logic [4:0] ack_delay = 5'h00;
    logic tx_ack;
    logic tx_req;
    logic [1:0] tx_slot;
    logic [3:0] tx_dlc;
    logic [1:0] tx_src;
    logic [2:0] tx_pending;
    logic [31:0] seed = 32'he80212d3;
    logic [3:0] armed = 4'hf;
    logic [3:0] thr_en = 4'h7;
    logic [3:0] pol = 4'h1;
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int cmp_count = 0;
    cat_auto_tx #(.PRESCALE(PRESCALE)) u_cat_auto_tx (.clk(clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
        .reg_wr_addr(reg_wr_addr), .reg_wr_mask(reg_wr_mask), .reg_wr_data(reg_wr_data),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .analog_input_cfg(analog_input_cfg),
        .adc_valid(adc_valid), .adc_channel(adc_channel), .adc_result(adc_result), .rx_warn(err_in[0]),
        .rx_passive(err_in[1]), .tx_warn(err_in[2]), .tx_passive(err_in[3]), .rx_overflow(err_in[4]),
        .tx_ack(tx_ack), .tx_req(tx_req), .tx_slot(tx_slot), .tx_dlc(tx_dlc), .tx_src(tx_src),
        .tx_pending(tx_pending));
    cat_can_engine u_cat_can_engine (.clk(clk), .rst_b(rst_b), .tx_req(tx_req), .ack_delay(ack_delay),
        .tx_ack(tx_ack));
    initial begin
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] got);
        cmp_count++;
        if (got !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, m, d);
        reg_wr_addr = a;
        reg_wr_mask = m;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        tick(1);
        reg_wr_en = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, e);
        reg_rd_addr = a;
        tick(1);
        cmp("read data", {24'h0, e}, {24'h0, reg_rd_data});
    endtask
    task automatic wait_ack(output int n);
        n = 0;
        while (!(tx_req === 1'b1 && tx_ack === 1'b1)) begin
            tick(1);
            n++;
            if (n > 20000) begin
                n_fail++;
                report_and_stop();
            end
        end
        tick(1);
    endtask
    // The bench keeps its own arm state per channel to predict each crossing.
    task automatic adc(input logic [1:0] ch, input logic [9:0] v);
        logic en;
        logic up;
        en = thr_en[ch] & analog_input_cfg[ch];
        up = pol[ch];
        if (en && armed[ch] && (up ? v >= HI : v <= LO)) begin
            armed[ch] = 1'b0;
            exp_q.push_back(F_EVT);
        end else if (en && (up ? v <= LO : v >= HI)) begin
            armed[ch] = 1'b1;
        end
        adc_channel = ch;
        adc_result = v;
        adc_valid = 1'b1;
        tick(1);
        adc_valid = 1'b0;
        tick(1);
    endtask
    // Sampled mid-cycle, where the handshake outputs have settled.
    always @(negedge clk) begin
        if (rst_b === 1'b1 && tx_req === 1'b1 && tx_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp("unexpected frame", 32'hxx, {24'h0, tx_slot, tx_dlc, tx_src});
            end else begin
                cmp("frame", {24'h0, exp_q.pop_front()}, {24'h0, tx_slot, tx_dlc, tx_src});
            end
        end
    end
    initial begin
        int n;
        int k;
        logic [3:0] m;
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        rd(cat_pkg::ADDR_SCHED, 8'h3f);
        rd(cat_pkg::ADDR_OPT2, 8'h00);
        rd(8'hff, 8'h00);
        for (int b = 0; b < 4; b++) begin
            m = (b == 0) ? 4'hf : 4'(3 - b);
            wr(cat_pkg::ADDR_SCHED, 8'hff, {1'b1, b[0], b[1:0], m});
            exp_q.push_back(b[0] ? F_P8 : F_P0);
            exp_q.push_back(b[0] ? F_P8 : F_P0);
            wait_ack(n);
            wait_ack(n);
            cmp("interval", PRESCALE * (1 << (4 * b)) * (m + 1), n + 1);
            wr(cat_pkg::ADDR_SCHED, 8'h80, 8'h00);
        end
        tick(40);
        $display("scheduler test done");
        wr(cat_pkg::ADDR_OPT2, 8'h20, 8'h20);
        for (int e = 0; e < 5; e++) begin
            exp_q.push_back(F_ERR);
            err_in[e] = 1'b1;
            wait_ack(n);
            tick(4);
            err_in[e] = 1'b0;
        end
        wr(cat_pkg::ADDR_OPT2, 8'h20, 8'h00);
        err_in = 5'h1f;
        tick(6);
        err_in = 5'h00;
        wr(cat_pkg::ADDR_OPT2, 8'h20, 8'h20);
        tick(20);
        rd(cat_pkg::ADDR_STATUS, 8'h78);
        $display("error test done");
        analog_input_cfg = 4'hd;
        wr(cat_pkg::ADDR_THR_EN, 8'hff, 8'hf7);
        wr(cat_pkg::ADDR_POLARITY, 8'hff, 8'h01);
        rd(cat_pkg::ADDR_THR_EN, 8'h07);
        rd(cat_pkg::ADDR_POLARITY, 8'h01);
        for (int c = 0; c < 4; c++) begin
            wr(cat_pkg::ADDR_CMP_BASE + 8'(c), 8'hff, 8'h40);
        end
        rd(cat_pkg::ADDR_CMP_BASE + 8'h2, 8'h40);
        for (k = 0; k < 400; k++) begin
            seed = lfsr(seed);
            ack_delay = seed[9:5];
            adc(seed[1:0], 10'h0fe + 10'(seed[4:2]));
            if (exp_q.size() != 0) begin
                wait_ack(n);
            end
        end
        $display("threshold test done");
        ack_delay = 5'h14;
        wr(cat_pkg::ADDR_SCHED, 8'hff, 8'h90);
        exp_q.push_back(F_P0);
        k = 0;
        while (tx_req !== 1'b1 && k < 200) begin
            tick(1);
            k++;
        end
        if (k >= 200) begin
            n_fail++;
            report_and_stop();
        end
        cmp("periodic offer", 32'h1, {31'h0, tx_req});
        wr(cat_pkg::ADDR_SCHED, 8'h80, 8'h00);
        adc(2'h0, LO);
        adc(2'h0, HI);
        exp_q.push_back(F_ERR);
        err_in[1] = 1'b1;
        tick(1);
        err_in[1] = 1'b0;
        repeat (3) wait_ack(n);
        tick(60);
        cmp("frames left", 32'h0, exp_q.size());
        rd(cat_pkg::ADDR_STATUS, {1'b0, armed, 3'h0});
        $display("priority test done");
        report_and_stop();
    end
endmodule
